// File: tb/link_port_select_status_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module link_port_select_status_regs_bench;
	import lpss_pkg::*;
	typedef struct packed {logic w; logic [7:0] off; logic [7:0] wd; logic [7:0] exp;} lpss_row_t;
	localparam lpss_row_t ROWS [8] = '{
		'{1'b0, 8'h1a, 8'h00, 8'h01}, '{1'b1, 8'h1a, 8'hff, 8'h00},
		'{1'b0, 8'h1a, 8'h00, 8'h81}, '{1'b1, 8'h1e, 8'hf9, 8'h00},
		'{1'b0, 8'h1e, 8'h00, 8'h01}, '{1'b0, 8'h1d, 8'h00, 8'h01},
		'{1'b0, 8'h1c, 8'h00, 8'hef}, '{1'b0, 8'h40, 8'h00, 8'h00}};
	localparam logic [6:0] DEV = 7'h2c;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, repeater_i = 1'b0, inband_valid_i = 1'b0;
	logic inband_surround_i = 1'b0, aux_audio_en_i = 1'b0, crc_err_clear_i = 1'b0;
	logic [1:0] crc_err_i = 2'b00, link_lost_i = 2'b00, selftest_start_i = 2'b00;
	logic [8:0] local_io_i = 9'h1ff;
	logic [3:0] remote_io_i = 4'ha;
	logic req_valid, req_write, ack_o, rd_link_o, sa_en, ad_en, sur, isl, ackv;
	logic [6:0] req_id;
	logic [7:0] req_off, req_wd, rd_data_o, rdv;
	logic [1:0] wr_link_mask_o;
	int n_mismatch = 0, checked = 0;
	always #5 clk_i = ~clk_i;
	lpss_host i_lpss_host (.clk_i(clk_i), .req_valid_o(req_valid), .req_write_o(req_write),
		.req_id_o(req_id), .req_off_o(req_off), .req_wd_o(req_wd), .ack_i(ack_o),
		.rd_data_i(rd_data_o));
	lpss_regs i_lpss_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid),
		.req_write_i(req_write), .req_slave_id_i(req_id), .req_offset_i(req_off),
		.req_wdata_i(req_wd), .dev_id_i(DEV), .repeater_i(repeater_i),
		.inband_valid_i(inband_valid_i), .inband_surround_i(inband_surround_i),
		.aux_audio_en_i(aux_audio_en_i), .crc_err_i(crc_err_i), .link_lost_i(link_lost_i),
		.selftest_start_i(selftest_start_i), .crc_err_clear_i(crc_err_clear_i),
		.local_io_i(local_io_i), .remote_io_i(remote_io_i), .ack_o(ack_o),
		.rd_data_o(rd_data_o), .wr_link_mask_o(wr_link_mask_o), .rd_link_o(rd_link_o),
		.second_addr_en_o(sa_en), .autodetect_en_o(ad_en), .surround_mode_o(sur),
		.data_island_o(isl));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic acc(input logic [6:0] id, input logic w, input logic [7:0] off,
		input logic [7:0] wd);
		i_lpss_host.access(w, id, off, wd, ackv, rdv);
	endtask : acc
	task automatic complete_run();
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask : tick
	initial begin
		repeat (3000) @(posedge clk_i);
		n_mismatch++;
		complete_run();
	end
	initial begin
		repeat (3) tick();
		sys_rst_i = 1'b0;
		chk({5'h00, sa_en, ack_o, sur}, 8'h01);
		foreach (ROWS[i]) begin
			acc(DEV, ROWS[i].w, ROWS[i].off, ROWS[i].wd);
			chk({7'h00, ackv}, 8'h01);
			if (!ROWS[i].w) chk(rdv, ROWS[i].exp);
		end
		aux_audio_en_i = 1'b1;
		acc(DEV, 1'b0, 8'h1a, 8'h00);
		chk(rdv, 8'h89);
		for (int i = 0; i < 3; i++) begin
			crc_err_i = (i == 0) ? 2'b11 : 2'b01;
			tick();
			crc_err_i = 2'b00;
		end
		acc(DEV, 1'b0, 8'h1b, 8'h00);
		chk(rdv, 8'h03);
		chk({7'h00, rd_link_o}, 8'h00);
		acc(DEV, 1'b1, 8'h1e, 8'h02);
		chk({6'h00, wr_link_mask_o}, 8'h01);
		acc(DEV, 1'b0, 8'h1b, 8'h00);
		chk(rdv, 8'h01);
		chk({7'h00, rd_link_o}, 8'h01);
		acc(DEV, 1'b0, 8'h1c, 8'h00);
		chk(rdv, 8'h0a);
		acc(DEV, 1'b1, 8'h1e, 8'h03);
		chk({6'h00, wr_link_mask_o}, 8'h02);
		acc(DEV, 1'b1, 8'h1e, 8'h03);
		chk({6'h00, wr_link_mask_o}, 8'h03);
		acc(DEV, 1'b0, 8'h1b, 8'h00);
		chk(rdv, 8'h01);
		chk({7'h00, rd_link_o}, 8'h01);
		acc(DEV, 1'b1, 8'h1e, 8'h01);
		for (int k = 0; k < 3; k++) begin
			crc_err_i = 2'b11;
			tick();
			crc_err_i = 2'b00;
			link_lost_i = (k == 0) ? 2'b11 : 2'b00;
			selftest_start_i = (k == 1) ? 2'b11 : 2'b00;
			crc_err_clear_i = (k == 2);
			tick();
			{link_lost_i, selftest_start_i, crc_err_clear_i} = 5'h00;
			acc(DEV, 1'b0, 8'h1b, 8'h00);
			chk(rdv, 8'h00);
		end
		acc(DEV, 1'b1, 8'h1e, 8'h07);
		tick();
		chk({7'h00, sa_en}, 8'h01);
		acc(DEV + 7'h01, 1'b0, 8'h1b, 8'h00);
		chk({6'h00, ackv, rd_link_o}, 8'h03);
		acc(DEV, 1'b0, 8'h1b, 8'h00);
		chk({6'h00, ackv, rd_link_o}, 8'h02);
		acc(DEV + 7'h01, 1'b1, 8'h1a, 8'h00);
		chk({6'h00, wr_link_mask_o}, 8'h02);
		acc(DEV + 7'h02, 1'b0, 8'h1a, 8'h00);
		chk({7'h00, ackv}, 8'h00);
		{repeater_i, inband_valid_i, inband_surround_i} = 3'b111;
		repeat (2) tick();
		chk({5'h00, ad_en, sur, isl}, 8'h07);
		acc(DEV, 1'b1, 8'h1a, 8'h80);
		repeat (2) tick();
		chk({5'h00, ad_en, sur, isl}, 8'h00);
		crc_err_i = 2'b01;
		repeat (256) tick();
		crc_err_i = 2'b00;
		acc(DEV, 1'b0, 8'h1b, 8'h00);
		chk(rdv, CRC_COUNT_MAX);
		sys_rst_i = 1'b1;
		tick();
		chk({4'h0, sa_en, ad_en, sur, isl}, 8'h03);
		chk({5'h00, ack_o, wr_link_mask_o}, 8'h00);
		sys_rst_i = 1'b0;
		acc(DEV, 1'b0, 8'h1a, 8'h00);
		chk(rdv, 8'h09);
		acc(DEV, 1'b0, 8'h1e, 8'h00);
		chk(rdv, RST_LINK_PORT_SELECT);
		acc(DEV, 1'b0, 8'h1b, 8'h00);
		chk(rdv, 8'h00);
		complete_run();
	end
endmodule : link_port_select_status_regs_bench
`default_nettype wire

// File: tb/lpss_host.sv
`timescale 1ns/10ps
`default_nettype none
module lpss_host (
	input  wire logic       clk_i,       // Register clock
	output logic            req_valid_o, // Request strobe
	output logic            req_write_o, // 1 write, 0 read
	output logic [6:0]      req_id_o,    // Slave address used
	output logic [7:0]      req_off_o,   // Register offset
	output logic [7:0]      req_wd_o,    // Write data
	input  wire logic       ack_i,       // Device answer
	input  wire logic [7:0] rd_data_i    // Read data
);
	initial begin
		req_valid_o = 1'b0;
		req_write_o = 1'b0;
		req_id_o = 7'h00;
		req_off_o = 8'h00;
		req_wd_o = 8'h00;
	end
	// Held until the taking edge, answer taken just after that same edge
	task automatic access(input logic w, input logic [6:0] id, input logic [7:0] off,
		input logic [7:0] wd, output logic ack, output logic [7:0] rd);
		@(posedge clk_i);
		#1;
		req_valid_o = 1'b1;
		req_write_o = w;
		req_id_o = id;
		req_off_o = off;
		req_wd_o = wd;
		@(posedge clk_i);
		#1;
		req_valid_o = 1'b0;
		req_wd_o = ~wd;
		req_off_o = ~off;
		ack = ack_i;
		rd = rd_data_i;
	endtask : access
endmodule : lpss_host
`default_nettype wire

// File: verilog/lpss_pkg.sv
package lpss_pkg;

	// Register offsets
	localparam logic [7:0] OFF_AUDIO_DATAPATH_CONTROL = 8'h1a;
	localparam logic [7:0] OFF_SELFTEST_BC_ERRORS     = 8'h1b;
	localparam logic [7:0] OFF_PIN_LEVEL_STATUS_LOW   = 8'h1c;
	localparam logic [7:0] OFF_PIN_LEVEL_STATUS_HIGH  = 8'h1d;
	localparam logic [7:0] OFF_LINK_PORT_SELECT       = 8'h1e;

	// audio_datapath_control fields
	localparam int BIT_AUTODETECT_BLOCK = 7;
	localparam int BIT_AUX_AUDIO        = 3;
	localparam int BIT_SURROUND_SELECT  = 0;

	// link_port_select fields
	localparam int BIT_SECOND_ADDR_EN = 2;
	localparam int BIT_LINK1_SEL      = 1;
	localparam int BIT_LINK0_SEL      = 0;

	// Reset values
	localparam logic [7:0] RST_AUDIO_DATAPATH_CONTROL = 8'h01;
	localparam logic [7:0] RST_SELFTEST_BC_ERRORS     = 8'h00;
	localparam logic [7:0] RST_PIN_LEVEL_STATUS       = 8'h00;
	localparam logic [7:0] RST_LINK_PORT_SELECT       = 8'h01;

	// Error counter limit and second address step
	localparam logic [7:0] CRC_COUNT_MAX    = 8'hff;
	localparam logic [6:0] SECOND_ADDR_STEP = 7'h01;

endpackage : lpss_pkg

// File: verilog/lpss_regs.sv
// Summary of operation
// - Autodetect-block bit 7 low lets a repeater derive audio mode in-band; high disables.
// - Read-only bit 3 mirrors the auxiliary audio enable held at offset 0x54.
// - Surround select resets to 1; 0 means two/four channel per register 0x12.
// - Surround audio travels only over the data-island audio transport.
// - In a repeater, in-band detected mode overrides surround select unless blocked.
// - Eight-bit self-test CRC error count clears on link loss, restart or clear control.
// - Error count kept per link; read shows link 1 when its window is selected.
// - Status bits 7..5 show local pins 7..5; read zero when link-1 window selected.
// - Status bits 3..0 show local pins 3..0, or second-link pins when link-1 selected.
// - Offset 0x1D bit 0 shows pin 8 level; other bits reserved.
// - Second-address enable makes the device answer device address plus one.
// - Link-1 window: primary writes reach link 1 and shared, reads return link 1.
// - Link-0 window (reset 1): primary writes reach link 0 and shared, reads link 0.
// - Both windows set: reads return link 1, writes update every selected link.
// - Window selects ignored under second-address enable; each address reaches own link.
`timescale 1ns/10ps
`default_nettype none
module lpss_regs
	import lpss_pkg::*;
(
	input  wire logic       clk_i,             // 100 MHz register clock
	input  wire logic       sys_rst_i,         // Synchronous reset, active high
	input  wire logic       req_valid_i,       // Register access request, one cycle
	input  wire logic       req_write_i,       // 1 write, 0 read
	input  wire logic [6:0] req_slave_id_i,    // 7-bit address the host used
	input  wire logic [7:0] req_offset_i,      // Register offset
	input  wire logic [7:0] req_wdata_i,       // Write data
	input  wire logic [6:0] dev_id_i,          // Primary 7-bit device address
	input  wire logic       repeater_i,        // Device runs as repeater
	input  wire logic       inband_valid_i,    // In-band audio mode detected
	input  wire logic       inband_surround_i, // Detected mode is surround
	input  wire logic       aux_audio_en_i,    // Auxiliary audio enable from 0x54
	input  wire logic [1:0] crc_err_i,         // Per-link back-channel CRC error pulse
	input  wire logic [1:0] link_lost_i,       // Per-link loss of link
	input  wire logic [1:0] selftest_start_i,  // Per-link self-test restart
	input  wire logic       crc_err_clear_i,   // CRC error clear control from 0x04
	input  wire logic [8:0] local_io_i,        // Local pin levels, asynchronous
	input  wire logic [3:0] remote_io_i,       // Second-link pin status
	output logic            ack_o,             // Access addressed to this device
	output logic [7:0]      rd_data_o,         // Read data, valid with ack_o
	output logic [1:0]      wr_link_mask_o,    // Links a write updated
	output logic            rd_link_o,         // Link a read returned
	output logic            second_addr_en_o,  // Answer second address
	output logic            autodetect_en_o,   // In-band audio mode detection on
	output logic            surround_mode_o,   // Surround audio in use
	output logic            data_island_o      // Data-island audio transport forced
);

	logic [7:0] audio_ctl_reg;
	logic [7:0] audio_ctl_next;
	logic [2:0] port_sel_reg;
	logic [2:0] port_sel_next;
	logic [7:0] crc_cnt_reg [2];
	logic [7:0] crc_cnt_next [2];
	logic [8:0] io_meta_reg;
	logic [8:0] io_sync_reg;
	logic       ack_reg;
	logic [7:0] rd_data_reg;
	logic [7:0] rd_data_next;
	logic [1:0] wr_mask_reg;
	logic       rd_link_reg;
	logic       sec_en_reg;
	logic       autodet_reg;
	logic       surround_reg;
	logic       island_reg;

	// Address decode
	wire        sec_en      = port_sel_reg[BIT_SECOND_ADDR_EN];
	wire        l1_sel      = port_sel_reg[BIT_LINK1_SEL];
	wire        l0_sel      = port_sel_reg[BIT_LINK0_SEL];
	wire [6:0]  second_id   = dev_id_i + SECOND_ADDR_STEP;
	wire        hit_primary = req_slave_id_i == dev_id_i;
	wire        hit_second  = sec_en && (req_slave_id_i == second_id);
	wire        hit         = req_valid_i && (hit_primary || hit_second);
	wire        wr_hit      = hit && req_write_i;

	// One answered read of the given register offset
	function automatic logic read_at(input logic [7:0] off);
		return hit && !req_write_i && (req_offset_i == off);
	endfunction : read_at

	// Link steering for port-specific registers
	// With the second address on, each address owns one link and the window bits are ignored
	wire        acc_link1   = sec_en ? hit_second : l1_sel;
	wire [1:0]  acc_wmask   = sec_en ? {hit_second, !hit_second}
	                                 : {l1_sel, l0_sel};

	// Audio mode
	wire        blocked     = audio_ctl_reg[BIT_AUTODETECT_BLOCK];
	wire        autodet     = repeater_i && !blocked;
	wire        surround    = (autodet && inband_valid_i) ? inband_surround_i
	                                                      : audio_ctl_reg[BIT_SURROUND_SELECT];

	// Register writes; reserved bits stay zero
	wire        wr_audio    = wr_hit && (req_offset_i == OFF_AUDIO_DATAPATH_CONTROL);
	wire        wr_port     = wr_hit && (req_offset_i == OFF_LINK_PORT_SELECT);

	always_comb begin
		audio_ctl_next = audio_ctl_reg;
		port_sel_next  = port_sel_reg;
		if (wr_audio) begin
			audio_ctl_next = 8'h00;
			audio_ctl_next[BIT_AUTODETECT_BLOCK] = req_wdata_i[BIT_AUTODETECT_BLOCK];
			audio_ctl_next[BIT_SURROUND_SELECT]  = req_wdata_i[BIT_SURROUND_SELECT];
		end
		if (wr_port) begin
			port_sel_next = req_wdata_i[2:0];
		end
	end

	// Per-link CRC error counters; clear conditions take priority
	always_comb begin
		for (int l = 0; l < 2; l++) begin
			crc_cnt_next[l] = crc_cnt_reg[l];
			if (link_lost_i[l] || selftest_start_i[l] || crc_err_clear_i) begin
				crc_cnt_next[l] = RST_SELFTEST_BC_ERRORS;
			end else if (crc_err_i[l] && (crc_cnt_reg[l] != CRC_COUNT_MAX)) begin
				crc_cnt_next[l] = crc_cnt_reg[l] + 8'h01;
			end
		end
	end

	// Read data
	wire [7:0] audio_view = {audio_ctl_reg[7:4], aux_audio_en_i,
	                         audio_ctl_reg[2:0]};
	wire [7:0] pins_low   = acc_link1 ? {4'h0, remote_io_i}
	                                  : {io_sync_reg[7:5], 1'b0, io_sync_reg[3:0]};
	wire [7:0] pins_high  = {7'h00, io_sync_reg[8]};
	wire [7:0] crc_view   = acc_link1 ? crc_cnt_reg[1] : crc_cnt_reg[0];

	always_comb begin
		case (req_offset_i)
			OFF_AUDIO_DATAPATH_CONTROL: rd_data_next = audio_view;
			OFF_SELFTEST_BC_ERRORS:     rd_data_next = crc_view;
			OFF_PIN_LEVEL_STATUS_LOW:   rd_data_next = pins_low;
			OFF_PIN_LEVEL_STATUS_HIGH:  rd_data_next = pins_high;
			OFF_LINK_PORT_SELECT:       rd_data_next = {5'h00, port_sel_reg};
			default:                    rd_data_next = 8'h00;
		endcase
	end

	// Pin synchroniser
	// Only the second stage feeds reads; the first may still be settling
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			io_meta_reg <= 9'h000;
			io_sync_reg <= 9'h000;
		end else begin
			io_meta_reg <= local_io_i;
			io_sync_reg <= io_meta_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			audio_ctl_reg  <= RST_AUDIO_DATAPATH_CONTROL;
			port_sel_reg   <= RST_LINK_PORT_SELECT[2:0];
			crc_cnt_reg[0] <= RST_SELFTEST_BC_ERRORS;
			crc_cnt_reg[1] <= RST_SELFTEST_BC_ERRORS;
		end else begin
			audio_ctl_reg  <= audio_ctl_next;
			port_sel_reg   <= port_sel_next;
			crc_cnt_reg[0] <= crc_cnt_next[0];
			crc_cnt_reg[1] <= crc_cnt_next[1];
		end
	end

	// Access answer
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ack_reg     <= 1'b0;
			rd_data_reg <= 8'h00;
			wr_mask_reg <= 2'b00;
			rd_link_reg <= 1'b0;
		end else begin
			ack_reg     <= hit;
			rd_data_reg <= (hit && !req_write_i) ? rd_data_next : 8'h00;
			wr_mask_reg <= wr_hit ? acc_wmask : 2'b00;
			rd_link_reg <= hit && !req_write_i && acc_link1;
		end
	end

	// Mode outputs
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sec_en_reg   <= 1'b0;
			autodet_reg  <= 1'b0;
			surround_reg <= RST_AUDIO_DATAPATH_CONTROL[BIT_SURROUND_SELECT];
			island_reg   <= RST_AUDIO_DATAPATH_CONTROL[BIT_SURROUND_SELECT];
		end else begin
			sec_en_reg   <= sec_en;
			autodet_reg  <= autodet;
			surround_reg <= surround;
			island_reg   <= surround;
		end
	end

	assign ack_o            = ack_reg;
	assign rd_data_o        = rd_data_reg;
	assign wr_link_mask_o   = wr_mask_reg;
	assign rd_link_o        = rd_link_reg;
	assign second_addr_en_o = sec_en_reg;
	assign autodetect_en_o  = autodet_reg;
	assign surround_mode_o  = surround_reg;
	assign data_island_o    = island_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	autodet_follow_a: assert property (
		(repeater_i && !audio_ctl_reg[BIT_AUTODETECT_BLOCK]) |=> autodetect_en_o)
		else $error("autodetect not enabled while unblocked");

	autodet_block_a: assert property (
		audio_ctl_reg[BIT_AUTODETECT_BLOCK] |=> !autodetect_en_o)
		else $error("autodetect enabled while blocked");

	aux_mirror_a: assert property (
		(req_valid_i && !req_write_i && hit_primary &&
		 req_offset_i == OFF_AUDIO_DATAPATH_CONTROL)
		|=> rd_data_o[BIT_AUX_AUDIO] == $past(aux_audio_en_i))
		else $error("aux audio bit does not mirror enable");

	island_surround_a: assert property (
		surround_mode_o |-> data_island_o)
		else $error("surround without data-island transport");

	override_mode_a: assert property (
		(repeater_i && !audio_ctl_reg[BIT_AUTODETECT_BLOCK] && inband_valid_i)
		|=> surround_mode_o == $past(inband_surround_i))
		else $error("in-band mode not applied");

	crc_clear_a: assert property (
		(link_lost_i[0] || selftest_start_i[0] || crc_err_clear_i)
		|=> crc_cnt_reg[0] == 8'h00)
		else $error("link 0 error count not cleared");

	crc_count_a: assert property (
		(crc_err_i[1] && !link_lost_i[1] && !selftest_start_i[1] && !crc_err_clear_i
		 && crc_cnt_reg[1] != 8'hff)
		|=> crc_cnt_reg[1] == $past(crc_cnt_reg[1]) + 8'h01)
		else $error("link 1 error count not incremented");

	crc_link_read_a: assert property (
		(req_valid_i && !req_write_i && hit_primary && !sec_en && l1_sel &&
		 req_offset_i == OFF_SELFTEST_BC_ERRORS)
		|=> rd_data_o == $past(crc_cnt_reg[1]) && rd_link_o)
		else $error("link 1 count not returned");

	pins_zero_a: assert property (
		(req_valid_i && !req_write_i && hit && acc_link1 &&
		 req_offset_i == OFF_PIN_LEVEL_STATUS_LOW)
		|=> rd_data_o[7:4] == 4'h0)
		else $error("upper pin bits not zero under link 1");

	second_addr_a: assert property (
		(req_valid_i && req_slave_id_i == dev_id_i + 7'h01 && req_slave_id_i != dev_id_i)
		|=> ack_o == $past(sec_en))
		else $error("second address answer wrong");

	both_sel_wr_a: assert property (
		(wr_hit && !sec_en && hit_primary && l0_sel && l1_sel) |=> wr_link_mask_o == 2'b11)
		else $error("write did not reach both links");

	sec_own_link_a: assert property (
		(wr_hit && sec_en && hit_primary) |=> wr_link_mask_o == 2'b01)
		else $error("primary write left link 0 under second address");

	reserved_zero_a: assert property (
		wr_audio |=> audio_ctl_reg[6:1] == 6'h00)
		else $error("reserved audio bits not zero");

	surround_select_a: assert property (
		!(autodet && inband_valid_i)
		|=> surround_mode_o == $past(audio_ctl_reg[BIT_SURROUND_SELECT]))
		else $error("surround select not applied");

	crc_increment_a: assert property (
		(crc_err_i[0] && !link_lost_i[0] && !selftest_start_i[0] && !crc_err_clear_i
		 && crc_cnt_reg[0] != CRC_COUNT_MAX)
		|=> crc_cnt_reg[0] == $past(crc_cnt_reg[0]) + 8'h01)
		else $error("link 0 error count not incremented");

	crc_saturate_a: assert property (
		(crc_cnt_reg[0] == CRC_COUNT_MAX && !link_lost_i[0] && !selftest_start_i[0]
		 && !crc_err_clear_i)
		|=> crc_cnt_reg[0] == CRC_COUNT_MAX)
		else $error("link 0 error count left saturation");

	crc_clear_link1_a: assert property (
		(link_lost_i[1] || selftest_start_i[1] || crc_err_clear_i)
		|=> crc_cnt_reg[1] == RST_SELFTEST_BC_ERRORS)
		else $error("link 1 error count not cleared");

	pins_local_a: assert property (
		(read_at(OFF_PIN_LEVEL_STATUS_LOW) && !acc_link1)
		|=> rd_data_o[7:5] == $past(io_sync_reg[7:5]) && rd_data_o[4] == 1'b0
		    && rd_data_o[3:0] == $past(io_sync_reg[3:0]))
		else $error("local pin levels not returned");

	pins_remote_a: assert property (
		(read_at(OFF_PIN_LEVEL_STATUS_LOW) && acc_link1)
		|=> rd_data_o[3:0] == $past(remote_io_i))
		else $error("second-link pin status not returned");

	pins_high_a: assert property (
		read_at(OFF_PIN_LEVEL_STATUS_HIGH)
		|=> rd_data_o == {7'h00, $past(io_sync_reg[8])})
		else $error("pin 8 level not returned");

	link1_mask_a: assert property (
		(wr_hit && !sec_en && l1_sel && !l0_sel) |=> wr_link_mask_o == 2'b10)
		else $error("write did not reach link 1 only");

	link0_mask_a: assert property (
		(wr_hit && !sec_en && l0_sel && !l1_sel) |=> wr_link_mask_o == 2'b01)
		else $error("write did not reach link 0 only");

	both_sel_rd_a: assert property (
		(read_at(OFF_SELFTEST_BC_ERRORS) && !sec_en && l0_sel && l1_sel)
		|=> rd_link_o && rd_data_o == $past(crc_cnt_reg[1]))
		else $error("read under both windows not from link 1");

	second_link_a: assert property (
		(wr_hit && hit_second) |=> wr_link_mask_o == 2'b10)
		else $error("second address write left link 1");

	select_update_a: assert property (
		wr_port |=> port_sel_reg == $past(req_wdata_i[2:0]))
		else $error("link port select not updated");

	unmapped_zero_a: assert property (
		(hit && !req_write_i && (req_offset_i < OFF_AUDIO_DATAPATH_CONTROL ||
		 req_offset_i > OFF_LINK_PORT_SELECT)) |=> rd_data_o == 8'h00)
		else $error("unmapped read not zero");

	unaddressed_quiet_a: assert property (
		!hit |=> !ack_o && rd_data_o == 8'h00 && wr_link_mask_o == 2'b00 && !rd_link_o)
		else $error("answer without addressed request");

	cov_second_read_c: cover property (req_valid_i && hit_second && !req_write_i);
	cov_crc_sat_c:     cover property (crc_cnt_reg[0] == 8'hff);
	cov_both_sel_c:    cover property (wr_hit && l0_sel && l1_sel && !sec_en);
	cov_override_c:    cover property (autodet && inband_valid_i && !inband_surround_i);
	cov_link1_pins_c:  cover property (read_at(OFF_PIN_LEVEL_STATUS_LOW) && acc_link1);

endmodule : lpss_regs
`default_nettype wire
